// file: core/pob_pkg.sv
package pob_pkg;

  // sample clock base and the phase shift window
  localparam int unsigned SYS_MHZ = 100;
  localparam int unsigned PH_MIN_MHZ = 20;
  localparam int unsigned PH_MAX_DIV = SYS_MHZ / PH_MIN_MHZ;

  // words allowed after the acknowledge drops, and words already on
  // their way before the drop is seen: two sync plus two output stages
  localparam logic [3:0] OVERRUN_WORDS = 4'h4;
  localparam logic [3:0] ACK_SLACK = 4'h4;

  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_DIV = 8'h08;
  localparam logic [7:0] REG_ROUTE = 8'h0C;
  localparam logic [7:0] REG_COUNT = 8'h10;
  localparam logic [7:0] REG_RETRIG = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_REMAIN = 8'h1C;
  localparam logic [7:0] REG_LEVEL = 8'h20;

  localparam int unsigned CTRL_GO = 0;
  localparam int unsigned CTRL_SWTRIG = 1;
  localparam int unsigned CTRL_ABORT = 2;

  localparam int unsigned CFG_WIDTH_LSB = 0;
  localparam int unsigned CFG_HS_EN = 2;
  localparam int unsigned CFG_HS_MODE2 = 3;
  localparam int unsigned CFG_START_TRIG = 4;
  localparam int unsigned CFG_SRC_EXT = 5;
  localparam int unsigned CFG_TMODE_LSB = 6;
  localparam int unsigned CFG_FALLING = 8;
  localparam int unsigned CFG_CLK_EXT = 9;
  localparam int unsigned CFG_EXP_LSB = 10;
  localparam int unsigned CFG_PHASE_LSB = 12;

  localparam int unsigned RT_REQ_LSB = 0;
  localparam int unsigned RT_ACK_LSB = 4;
  localparam int unsigned RT_TRIG_LSB = 8;
  localparam int unsigned RT_GATE_LSB = 12;
  localparam int unsigned RT_PULSE_LSB = 16;
  localparam int unsigned RT_PULSE_EN = 19;

  localparam logic [31:0] CFG_RST = 32'h0000_0004;
  localparam logic [15:0] DIV_RST = 16'h0001;
  localparam logic [31:0] ROUTE_RST = 32'h0000_3210;
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;
  localparam logic [15:0] RETRIG_RST = 16'h0001;

  localparam logic [2:0] LINE_SCLK = 3'h6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {POB_W32, POB_W24, POB_W16, POB_W8} pob_width_t;
  typedef enum logic [1:0] {
    POB_TM_POST, POB_TM_GATED, POB_TM_RETRIG, POB_TM_RSVD
  } pob_tmode_t;
  typedef enum logic [1:0] {
    POB_EXP_NONE, POB_EXP_LINE6, POB_EXP_COAX, POB_EXP_RSVD
  } pob_export_t;

endpackage

// file: core/pob_fifo.sv
`timescale 1ns/10ps
module pob_fifo #(
  parameter int unsigned W = 32,
  parameter int unsigned DEPTH_LOG = 4
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_wr_en,
  input wire logic [W-1:0] i_wr_data,
  input wire logic i_rd_en,
  output logic [W-1:0] o_rd_data,
  output logic [DEPTH_LOG:0] o_count
);
  localparam int unsigned DEPTH = 1 << DEPTH_LOG;

  logic [W-1:0] mem_q [DEPTH];
  logic [DEPTH_LOG-1:0] wp_q;
  logic [DEPTH_LOG-1:0] rp_q;
  logic [DEPTH_LOG:0] count_q;
  logic [W-1:0] rd_data_q;

  // caller guarantees no write when full and no read when empty
  always_ff @(posedge i_clk) begin
    if (i_ce && i_wr_en) begin
      mem_q[wp_q] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wp_q <= '0;
      rp_q <= '0;
      count_q <= '0;
      rd_data_q <= '0;
    end else if (i_ce) begin
      if (i_wr_en) begin
        wp_q <= wp_q + 1'b1;
      end
      if (i_rd_en) begin
        rp_q <= rp_q + 1'b1;
        rd_data_q <= mem_q[rp_q];
      end
      case ({i_wr_en, i_rd_en})
        2'b10: count_q <= count_q + 1'b1;
        2'b01: count_q <= count_q - 1'b1;
        default: count_q <= count_q;
      endcase
    end
  end

  assign o_rd_data = rd_data_q;
  assign o_count = count_q;
endmodule

// file: core/pob_engine.sv
`timescale 1ns/10ps
module pob_engine
  import pob_pkg::*;
#(
  parameter int unsigned FIFO_LOG = 4,
  parameter int unsigned CNT_W = 32,
  parameter logic [1:0] ACK_CONFIRM = 2'h2
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_dma_valid,
  input wire logic [31:0] i_dma_data,
  output logic o_dma_ready,
  input wire logic [7:0] i_fl_in,
  output logic [7:0] o_fl_out,
  output logic [7:0] o_fl_oe,
  output logic [31:0] o_data,
  output logic o_sclk,
  output logic o_coax_clk
);
  localparam int unsigned DEPTH = 1 << FIFO_LOG;

  typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_RUN} pob_state_t;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] ws);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (ws[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] width_mask(input pob_width_t w);
    case (w)
      POB_W32: return 32'hFFFF_FFFF;
      POB_W24: return 32'h00FF_FFFF;
      POB_W16: return 32'h0000_FFFF;
      default: return 32'h0000_00FF;
    endcase
  endfunction

  // bus slave
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_got_q, w_got_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_fire, w_mapped, r_mapped;
  logic [31:0] rd_mux;

  // registers and engine state
  logic [31:0] cfg_q, lcfg_q, route_q;
  logic [15:0] div_q, retrig_q, trig_left_q, div_cnt_q;
  logic [CNT_W-1:0] count_q, remain_q;
  pob_state_t state_q;
  logic done_q;
  logic [7:0] fl_s1_q, fl_s2_q, fl_s3_q;
  logic [7:0] ext_cnt_q, ext_per_q;
  logic [3:0] credit_q;
  logic [1:0] ack_cnt_q;
  logic bursting_q, send_d1_q, sclk_q, coax_q, sw_pulse_q, dma_ready_q;
  logic [2:0] sclk_dly_q;
  logic [31:0] data_q;
  logic [7:0] fl_out_q, fl_oe_q, fl_out_d, fl_oe_d;

  logic cmd_go, cmd_swtrig, cmd_abort;
  logic [2:0] rt_req, rt_ack, rt_trig, rt_gate, rt_pulse;
  logic hs_en, mode2, start_trig, src_ext, falling, clk_ext;
  pob_tmode_t tmode;
  pob_export_t exp_sel;
  logic [1:0] phase;
  logic ack_s, gate_lvl, ext_edge, trig_hit, tick_int, tick_ext, tick;
  logic gate_ok, start_ok, hs_grant, send, req_d, phase_ok, exp_clk;
  logic fifo_empty, fifo_wr;
  logic [3:0] sclk_pipe;
  logic [31:0] fifo_rd;
  logic [FIFO_LOG:0] fifo_count;

  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
  assign w_mapped = waddr_q inside {REG_CTRL, REG_CFG, REG_DIV, REG_ROUTE,
                    REG_COUNT, REG_RETRIG, REG_STATUS, REG_REMAIN, REG_LEVEL};
  assign r_mapped = i_araddr inside {REG_CTRL, REG_CFG, REG_DIV, REG_ROUTE,
                    REG_COUNT, REG_RETRIG, REG_STATUS, REG_REMAIN, REG_LEVEL};
  assign cmd_go = wr_fire && waddr_q == REG_CTRL && wstrb_q[0] &&
                  wdata_q[CTRL_GO];
  assign cmd_swtrig = wr_fire && waddr_q == REG_CTRL && wstrb_q[0] &&
                      wdata_q[CTRL_SWTRIG];
  assign cmd_abort = wr_fire && waddr_q == REG_CTRL && wstrb_q[0] &&
                     wdata_q[CTRL_ABORT];

  // address and data may arrive in either order
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (i_ce) begin
      if (i_awvalid && awready_q) begin
        waddr_q <= i_awaddr;
        aw_got_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (i_wvalid && wready_q) begin
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
        w_got_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= w_mapped ? RESP_OKAY : RESP_SLVERR;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
      end
      if (bvalid_q && i_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_araddr)
      REG_CFG: rd_mux = cfg_q;
      REG_DIV: rd_mux = {16'h0000, div_q};
      REG_ROUTE: rd_mux = route_q;
      REG_COUNT: rd_mux = 32'(count_q);
      REG_RETRIG: rd_mux = {16'h0000, retrig_q};
      REG_STATUS: rd_mux = {25'h0, ack_s, req_d, done_q, fifo_empty,
                            tmode == POB_TM_GATED && !gate_lvl,
                            state_q == ST_ARM, state_q != ST_IDLE};
      REG_REMAIN: rd_mux = 32'(remain_q);
      REG_LEVEL: rd_mux = 32'(fifo_count);
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (i_ce) begin
      if (i_arvalid && arready_q) begin
        rdata_q <= rd_mux;
        rresp_q <= r_mapped ? RESP_OKAY : RESP_SLVERR;
        rvalid_q <= 1'b1;
        arready_q <= 1'b0;
      end else if (rvalid_q && i_rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cfg_q <= CFG_RST;
      div_q <= DIV_RST;
      route_q <= ROUTE_RST;
      count_q <= CNT_W'(COUNT_RST);
      retrig_q <= RETRIG_RST;
    end else if (i_ce && wr_fire) begin
      case (waddr_q)
        REG_CFG: cfg_q <= merge(cfg_q, wdata_q, wstrb_q);
        REG_DIV: div_q <= 16'(merge({16'h0000, div_q}, wdata_q, wstrb_q));
        REG_ROUTE: route_q <= merge(route_q, wdata_q, wstrb_q);
        REG_COUNT: count_q <= CNT_W'(merge(32'(count_q), wdata_q, wstrb_q));
        REG_RETRIG:
          retrig_q <= 16'(merge({16'h0000, retrig_q}, wdata_q, wstrb_q));
        default: cfg_q <= cfg_q;
      endcase
    end
  end

  // live routing, latched run configuration
  assign rt_req = route_q[RT_REQ_LSB +: 3];
  assign rt_ack = route_q[RT_ACK_LSB +: 3];
  assign rt_trig = route_q[RT_TRIG_LSB +: 3];
  assign rt_gate = route_q[RT_GATE_LSB +: 3];
  assign rt_pulse = route_q[RT_PULSE_LSB +: 3];
  assign hs_en = lcfg_q[CFG_HS_EN];
  assign mode2 = lcfg_q[CFG_HS_MODE2];
  assign start_trig = lcfg_q[CFG_START_TRIG];
  assign src_ext = lcfg_q[CFG_SRC_EXT];
  assign tmode = pob_tmode_t'(lcfg_q[CFG_TMODE_LSB +: 2]);
  assign falling = lcfg_q[CFG_FALLING];
  assign clk_ext = lcfg_q[CFG_CLK_EXT];
  assign exp_sel = pob_export_t'(lcfg_q[CFG_EXP_LSB +: 2]);
  assign phase = lcfg_q[CFG_PHASE_LSB +: 2];

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      fl_s1_q <= '0;
      fl_s2_q <= '0;
      fl_s3_q <= '0;
    end else if (i_ce) begin
      fl_s1_q <= i_fl_in;
      fl_s2_q <= fl_s1_q;
      fl_s3_q <= fl_s2_q;
    end
  end

  assign ack_s = fl_s2_q[rt_ack];
  assign gate_lvl = fl_s2_q[rt_gate];
  assign ext_edge = falling ? (fl_s3_q[rt_trig] && !fl_s2_q[rt_trig]) :
                    (fl_s2_q[rt_trig] && !fl_s3_q[rt_trig]);
  assign trig_hit = src_ext ? ext_edge : cmd_swtrig;
  assign tick_ext = fl_s2_q[LINE_SCLK] && !fl_s3_q[LINE_SCLK];
  assign tick_int = div_cnt_q + 16'h0001 >= div_q; // n = 0 acts as 1
  assign tick = clk_ext ? tick_ext : tick_int;
  assign fifo_empty = fifo_count == '0;
  assign gate_ok = tmode != POB_TM_GATED || gate_lvl;
  assign start_ok = mode2 ? ack_cnt_q == ACK_CONFIRM : ack_s;
  assign hs_grant = !hs_en ||
                    (bursting_q ? (ack_s || credit_q != 4'h0) : start_ok);
  assign send = state_q == ST_RUN && tick && !fifo_empty &&
                remain_q != '0 && gate_ok && hs_grant;
  assign req_d = state_q != ST_IDLE && !fifo_empty;

  // divide the 100 MHz clock by n
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      div_cnt_q <= '0;
    end else if (i_ce) begin
      div_cnt_q <= tick_int ? 16'h0000 : div_cnt_q + 16'h0001;
    end
  end

  // external clock period, to judge the phase shift window
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ext_cnt_q <= '0;
      ext_per_q <= '0;
    end else if (i_ce) begin
      if (tick_ext) begin
        ext_per_q <= ext_cnt_q + 8'h01;
        ext_cnt_q <= 8'h00;
      end else if (ext_cnt_q != 8'hFF) begin
        ext_cnt_q <= ext_cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
      lcfg_q <= CFG_RST;
      remain_q <= '0;
      trig_left_q <= '0;
      done_q <= 1'b0;
    end else if (i_ce) begin
      case (state_q)
        ST_IDLE: begin
          if (cmd_go) begin
            lcfg_q <= cfg_q;
            remain_q <= count_q;
            trig_left_q <= retrig_q == '0 ? 16'h0000 : retrig_q - 16'h0001;
            done_q <= 1'b0;
            if (cfg_q[CFG_START_TRIG] &&
                cfg_q[CFG_TMODE_LSB +: 2] != POB_TM_GATED) begin
              state_q <= ST_ARM;
            end else begin
              state_q <= ST_RUN;
            end
          end
        end
        ST_ARM: begin
          if (trig_hit) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (remain_q == '0 || (send && remain_q == CNT_W'(1))) begin
            if (tmode == POB_TM_RETRIG && trig_left_q != '0) begin
              trig_left_q <= trig_left_q - 16'h0001;
              remain_q <= count_q;
              state_q <= ST_ARM;
            end else begin
              state_q <= ST_IDLE;
              done_q <= 1'b1;
              remain_q <= '0;
            end
          end else if (send) begin
            remain_q <= remain_q - CNT_W'(1);
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      if (cmd_abort) begin
        state_q <= ST_IDLE;
      end
    end
  end

  // sync latency is charged against the four-word overrun
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      credit_q <= '0;
      ack_cnt_q <= '0;
      bursting_q <= 1'b0;
    end else if (i_ce) begin
      if (ack_s) begin
        credit_q <= OVERRUN_WORDS - ACK_SLACK;
      end else if (send && credit_q != 4'h0) begin
        credit_q <= credit_q - 4'h1;
      end
      if (!ack_s) begin
        ack_cnt_q <= '0;
      end else if (ack_cnt_q != ACK_CONFIRM) begin
        ack_cnt_q <= ack_cnt_q + 2'h1;
      end
      if (state_q != ST_RUN || fifo_empty || (!ack_s && credit_q == 4'h0)) begin
        bursting_q <= 1'b0;
      end else if (send) begin
        bursting_q <= 1'b1;
      end
    end
  end

  assign fifo_wr = i_dma_valid && dma_ready_q;

  pob_fifo #(
    .W(32),
    .DEPTH_LOG(FIFO_LOG)
  ) u_fifo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_wr_en(fifo_wr),
    .i_wr_data(i_dma_data),
    .i_rd_en(send),
    .o_rd_data(fifo_rd),
    .o_count(fifo_count)
  );

  // data held between words, so a pause freezes the pins
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      dma_ready_q <= 1'b0;
      send_d1_q <= 1'b0;
      data_q <= '0;
      sclk_q <= 1'b0;
      sclk_dly_q <= '0;
      sw_pulse_q <= 1'b0;
    end else if (i_ce) begin
      dma_ready_q <= fifo_count <= (FIFO_LOG+1)'(DEPTH - 2);
      send_d1_q <= send;
      if (send_d1_q) begin
        data_q <= fifo_rd & width_mask(pob_width_t'(lcfg_q[1:0]));
      end
      sclk_q <= send_d1_q;
      sclk_dly_q <= sclk_pipe[2:0];
      sw_pulse_q <= cmd_swtrig;
    end
  end

  assign sclk_pipe = {sclk_dly_q, sclk_q};
  assign phase_ok = clk_ext ?
                    (ext_per_q != 8'h00 && ext_per_q <= 8'(PH_MAX_DIV)) :
                    (div_q <= 16'(PH_MAX_DIV));
  assign exp_clk = phase_ok ? sclk_pipe[phase] : sclk_q;

  // later entries win where two functions share a line
  always_comb begin
    fl_out_d = 8'h00;
    fl_oe_d = 8'h00;
    if (route_q[RT_PULSE_EN]) begin
      fl_out_d[rt_pulse] = sw_pulse_q;
      fl_oe_d[rt_pulse] = 1'b1;
    end
    if (exp_sel == POB_EXP_LINE6) begin
      fl_out_d[LINE_SCLK] = exp_clk;
      fl_oe_d[LINE_SCLK] = 1'b1;
    end
    if (hs_en) begin
      fl_out_d[rt_req] = req_d;
      fl_oe_d[rt_req] = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      fl_out_q <= '0;
      fl_oe_q <= '0;
      coax_q <= 1'b0;
    end else if (i_ce) begin
      fl_out_q <= fl_out_d;
      fl_oe_q <= fl_oe_d;
      coax_q <= exp_sel == POB_EXP_COAX && exp_clk;
    end
  end

  assign o_awready = awready_q;
  assign o_wready = wready_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_arready = arready_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;
  assign o_dma_ready = dma_ready_q;
  assign o_fl_out = fl_out_q;
  assign o_fl_oe = fl_oe_q;
  assign o_data = data_q;
  assign o_sclk = sclk_q;
  assign o_coax_clk = coax_q;
endmodule

// file: testbench/pob_rx_model.sv
`timescale 1ns/10ps
module pob_rx_model #(
  parameter int CAP = 8
) (
  input wire logic i_clk,
  input wire logic i_en,
  input wire logic i_sclk,
  input wire logic [31:0] i_data,
  output logic o_ack,
  output logic o_ovf
);
  logic [31:0] got[$];
  initial begin
    o_ack = 1'b0;
    o_ovf = 1'b0;
  end
  // keeps four slots free so words sent after the drop still fit
  always @(posedge i_clk) begin
    if (i_sclk) got.push_back(i_data);
    o_ack <= i_en && (got.size() < CAP - 4);
    if (got.size() > CAP) o_ovf <= 1'b1;
  end
endmodule

// file: testbench/pob_engine_chk.sv
`timescale 1ns/10ps
module pob_engine_chk
  import pob_pkg::*;
#(
  parameter int REQ_L = 3,
  parameter int ACK_L = 4,
  parameter int PUL_L = 5
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic o_bvalid,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic [7:0] i_fl_in,
  input wire logic [7:0] o_fl_out,
  input wire logic [7:0] o_fl_oe,
  input wire logic [31:0] o_data,
  input wire logic o_sclk
);
  logic [2:0] ovr_q;
  // words sent since the acknowledge pin fell, handshake only
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_fl_in[ACK_L]) ovr_q <= 3'h0;
    else if (o_sclk && o_fl_oe[REQ_L] && ovr_q != 3'h7)
      ovr_q <= ovr_q + 3'h1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence sw_fire;
    i_awvalid && o_awready && i_wvalid && o_wready &&
    i_awaddr == REG_CTRL && i_wdata[CTRL_SWTRIG] && i_wstrb[0];
  endsequence
  sequence one_pulse;
    ##[1:3] (o_fl_out[PUL_L] && o_fl_oe[PUL_L]) ##1 !o_fl_out[PUL_L];
  endsequence
  chk_sw_pulse: assert property (sw_fire |-> one_pulse)
    else $error("no pulse after software trigger");
  chk_ovr_bound: assert property (ovr_q <= 3'h4)
    else $error("too many words after acknowledge drop");
  chk_data_hold: assert property ($changed(o_data) |-> o_sclk)
    else $error("data changed without sample strobe");
  chk_w_answer: assert property
    (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
    else $error("write response late");
  chk_r_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read response late");
  chk_aw_block: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken while response pending");
  chk_ar_block: assert property (o_rvalid |-> !o_arready)
    else $error("read taken while response pending");
  chk_rerr_zero: assert property
    (o_rvalid && o_rresp == RESP_SLVERR |-> o_rdata == 32'h0000_0000)
    else $error("error read carries data");
endmodule

bind pob_engine pob_engine_chk chk_u (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_awvalid(i_awvalid),
  .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid),
  .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
  .o_bvalid(o_bvalid), .i_arvalid(i_arvalid), .o_arready(o_arready),
  .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_rresp(o_rresp),
  .i_fl_in(i_fl_in), .o_fl_out(o_fl_out), .o_fl_oe(o_fl_oe),
  .o_data(o_data), .o_sclk(o_sclk));

// file: testbench/tb.sv
`timescale 1ns/10ps
module tb;
  import pob_pkg::*;
  logic i_clk = 0, rst = 1, awv = 0, wv = 0, arv = 0, dv = 0;
  logic trig = 0, gate = 0, en = 0, ack, ovf;
  logic awr, wrd, bv, arr, rv, drdy, sclk, coax;
  logic [3:0] ws = 4'hF;
  logic [1:0] br, rr;
  logic [7:0] awa = 0, ara = 0, fl_in, ext, flo, floe;
  logic [31:0] wd = 0, dd = 0, rdat, dat;
  int n_mismatch = 0, checks_done = 0, cyc = 0, last = 0, gap = 0, k;
  int n_coax = 0;
  always #5 i_clk = ~i_clk;
  assign ext = {3'h0, ack, 1'b0, gate, trig, 1'b0};
  always_comb for (int i = 0; i < 8; i++) fl_in[i] = floe[i] ? flo[i] : ext[i];
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (coax) n_coax <= n_coax + 1;
    if (sclk) begin
      gap <= cyc - last;
      last <= cyc;
    end
  end
  pob_engine dut_u (.i_clk(i_clk), .i_sys_rst(rst), .i_ce(1'b1),
    .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa), .i_wvalid(wv),
    .o_wready(wrd), .i_wdata(wd), .i_wstrb(ws), .o_bvalid(bv),
    .i_bready(1'b1), .o_bresp(br), .i_arvalid(arv), .o_arready(arr),
    .i_araddr(ara), .o_rvalid(rv), .i_rready(1'b1), .o_rdata(rdat),
    .o_rresp(rr), .i_dma_valid(dv), .i_dma_data(dd), .o_dma_ready(drdy),
    .i_fl_in(fl_in), .o_fl_out(flo), .o_fl_oe(floe), .o_data(dat),
    .o_sclk(sclk), .o_coax_clk(coax));
  pob_rx_model rx_u (.i_clk(i_clk), .i_en(en), .i_sclk(sclk),
    .i_data(dat), .o_ack(ack), .o_ovf(ovf));
  task automatic print_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tmo();
    n_mismatch++;
    print_verdict();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int n;
    awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
      if (bv) break;
    end
    if (n == 50) tmo();
    cmp(br, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    arv <= 1'b1; ara <= a;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk);
      if (arv && arr) arv <= 1'b0;
      if (rv) break;
    end
    if (n == 50) tmo();
    d = rdat;
    r = rr;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    cmp(d, e);
    cmp(r, er);
  endtask
  task automatic wait_done();
    logic [31:0] s;
    logic [1:0] r;
    int n;
    for (n = 0; n < 300; n++) begin
      rd(REG_STATUS, s, r);
      if (s[4] === 1'b1) break;
    end
    if (n == 300) tmo();
    // last word reaches the receiver a few edges after done
    repeat (4) @(posedge i_clk);
  endtask
  task automatic push(input logic [31:0] b, input int c);
    int n;
    for (int j = 0; j < c; j++) begin
      dv <= 1'b1; dd <= b + j;
      for (n = 0; n < 50; n++) begin
        @(posedge i_clk);
        if (drdy) break;
      end
      if (n == 50) tmo();
    end
    dv <= 1'b0;
  endtask
  task automatic pops(input logic [31:0] b, input int c,
                      input logic [31:0] m);
    for (int j = 0; j < c; j++) cmp(rx_u.got.pop_front(), (b + j) & m);
    cmp(rx_u.got.size(), 0);
  endtask
  task automatic go(input logic [31:0] cfg, input logic [31:0] cnt);
    wr(REG_CFG, cfg, RESP_OKAY);
    wr(REG_COUNT, cnt, RESP_OKAY);
    wr(REG_CTRL, 32'h0000_0001, RESP_OKAY);
    repeat (20) @(posedge i_clk);
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    rst <= 1'b0;
    @(posedge i_clk);
    rc(REG_CFG, CFG_RST, RESP_OKAY);
    rc(REG_DIV, {16'h0000, DIV_RST}, RESP_OKAY);
    rc(REG_ROUTE, ROUTE_RST, RESP_OKAY);
    rc(REG_RETRIG, {16'h0000, RETRIG_RST}, RESP_OKAY);
    rc(8'h40, 32'h0000_0000, RESP_SLVERR);
    wr(8'h40, 32'h0000_0001, RESP_SLVERR);
    ws <= 4'h1;
    wr(REG_CFG, 32'hFFFF_FFFF, RESP_OKAY);
    ws <= 4'hF;
    rc(REG_CFG, {CFG_RST[31:8], 8'hFF}, RESP_OKAY);
    wr(REG_ROUTE, 32'h000D_2143, RESP_OKAY);
    rc(REG_ROUTE, 32'h000D_2143, RESP_OKAY);
    wr(REG_DIV, 32'h0000_0003, RESP_OKAY);
    for (int w = 0; w < 4; w++) begin
      push(32'hA5C3_E7F0, 2);
      go(w, 2);
      wait_done();
      pops(32'hA5C3_E7F0, 2, 32'hFFFF_FFFF >> (8 * w));
      cmp(gap, 3);
    end
    wr(REG_DIV, 32'h0000_0001, RESP_OKAY);
    for (int m = 0; m < 2; m++) begin
      en <= 1'b0;
      push(32'h1000_0000, 12);
      go(32'h0000_0004 | (m << 3), 12);
      cmp(flo[3], 1);
      cmp(rx_u.got.size(), 0);
      en <= 1'b1;
      k = 0;
      for (int t = 0; t < 20 && k < 12; t++) begin
        repeat (30) @(posedge i_clk);
        cmp(rx_u.got.size() <= 8, 1);
        while (rx_u.got.size() > 0) begin
          cmp(rx_u.got.pop_front(), 32'h1000_0000 + k);
          k++;
        end
      end
      cmp(k, 12);
      wait_done();
      cmp(flo[3], 0);
    end
    cmp(ovf, 0);
    push(32'h2000_0000, 4);
    wr(REG_RETRIG, 32'h0000_0002, RESP_OKAY);
    go(32'h0000_00B0, 2);
    cmp(rx_u.got.size(), 0);
    for (int p = 1; p < 3; p++) begin
      trig <= 1'b1;
      repeat (4) @(posedge i_clk);
      trig <= 1'b0;
      repeat (30) @(posedge i_clk);
      cmp(rx_u.got.size(), 2 * p);
    end
    wait_done();
    pops(32'h2000_0000, 4, 32'hFFFF_FFFF);
    push(32'h3000_0000, 1);
    go(32'h0000_0810, 1);
    cmp(rx_u.got.size(), 0);
    wr(REG_CTRL, 32'h0000_0002, RESP_OKAY);
    wait_done();
    pops(32'h3000_0000, 1, 32'hFFFF_FFFF);
    cmp(n_coax, 1);
    push(32'h4000_0000, 4);
    go(32'h0000_0040, 4);
    cmp(rx_u.got.size(), 0);
    rc(REG_REMAIN, 32'h0000_0004, RESP_OKAY);
    gate <= 1'b1;
    wait_done();
    pops(32'h4000_0000, 4, 32'hFFFF_FFFF);
    print_verdict();
  end
endmodule
